// File: odtm_regs.svh
/*
  Constants of the tributary time-division multiplexer: sizes, payload type
  codes, per-container capacity tables and buffer thresholds.
  Assumes it is included by bare name from the package and from the top module.
*/
`ifndef ODTM_REGS_SVH
`define ODTM_REGS_SVH

`define ODTM_NTRIB     8
`define ODTM_TW        3
`define ODTM_DW        32
`define ODTM_SW        12
`define ODTM_PT_AMP    8'h20
`define ODTM_PT_MIX    8'h21
`define ODTM_PT_CN     8'h22
// byte per rate, order {flex,4,3,2e,2,1,0}; limits, slots per unit, AMP mask, total slots
`define ODTM_LIM_O1    56'h00_00_00_00_00_00_02
`define ODTM_SLT_O1    56'h00_00_00_00_00_00_01
`define ODTM_AMP_O1    7'h01
`define ODTM_CAP_O1    12'h002
`define ODTM_LIM_O2A   56'h00_00_00_00_00_04_00
`define ODTM_SLT_O2A   56'h00_00_00_00_00_01_00
`define ODTM_AMP_O2A   7'h02
`define ODTM_CAP_O2A   12'h004
`define ODTM_LIM_O3A   56'h00_00_00_00_04_10_00
`define ODTM_SLT_O3A   56'h00_00_00_00_04_01_00
`define ODTM_AMP_O3A   7'h06
`define ODTM_CAP_O3A   12'h010
`define ODTM_LIM_O2M   56'h08_00_00_00_00_04_08
`define ODTM_SLT_O2M   56'h00_00_00_00_00_02_01
`define ODTM_AMP_O2M   7'h02
`define ODTM_CAP_O2M   12'h008
`define ODTM_LIM_O3M   56'h20_00_00_03_04_10_20
`define ODTM_SLT_O3M   56'h00_00_00_09_08_02_01
`define ODTM_AMP_O3M   7'h06
`define ODTM_CAP_O3M   12'h020
`define ODTM_LIM_O4    56'h50_00_02_0A_0A_28_50
`define ODTM_SLT_O4    56'h00_00_1F_08_08_02_01
`define ODTM_CAP_O4    12'h050
`define ODTM_LIM_O25   56'h14_00_00_02_02_0A_14
`define ODTM_SLT_O25   56'h00_00_00_08_08_02_01
`define ODTM_CAP_O25   12'h014
`define ODTM_LIM_O50   56'h28_00_01_05_05_14_28
`define ODTM_SLT_O50   56'h00_00_1F_08_08_02_01
`define ODTM_CAP_O50   12'h028
`define ODTM_SLT_CN    56'h00_14_08_02_02_01_01
`define ODTM_BUF_FULL  3'h2
`endif

// File: odtm_pkg.sv
/*
  Types of the tributary multiplexer: configuration, output word, states.
  Assumes odtm_regs.svh sits in the same folder.
*/
`default_nettype none
package odtm_pkg;
`include "odtm_regs.svh"

  typedef enum logic [2:0] {ODTM_C1, ODTM_C2, ODTM_C3, ODTM_C4, ODTM_C25, ODTM_C50, ODTM_CN} odtm_cont_t;
  typedef enum logic [2:0] {RATE_0, RATE_1, RATE_2, RATE_2E, RATE_3, RATE_4, RATE_FLEX} odtm_rate_t;
  typedef enum logic [2:0] {ERR_NONE, ERR_PT, ERR_RATE, ERR_TS, ERR_COUNT, ERR_SLOTS} odtm_err_t;
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_FINAL, ST_RUN, ST_FAULT} odtm_fsm_t;

  typedef struct packed {
    odtm_cont_t  cont;
    logic [7:0]  pt;
    logic [3:0]  n;
  } odtm_cfg_t;

  typedef struct packed {
    logic        en;
    odtm_rate_t  rate;
    logic [7:0]  ts;
  } odtm_trib_cfg_t;

  typedef struct packed {
    logic [`ODTM_TW-1:0] trib;
    logic                used;
    logic                fill;
    logic                amp;
    logic                part;
    logic [`ODTM_SW-1:0] slot;
    logic [`ODTM_DW-1:0] data;
  } odtm_word_t;

  typedef struct packed {
    logic                pt_ok;
    logic [7:0]          limit;
    logic [`ODTM_SW-1:0] slots;
    logic                amp;
    logic                part;
    logic [`ODTM_SW-1:0] cap;
  } odtm_lk_t;

  typedef struct packed {
    logic [1:0]       v;
    odtm_word_t [1:0] e;
  } odtm_buf_st_t;

  typedef struct packed {
    odtm_fsm_t                                fsm;
    odtm_cfg_t                                cfg;
    odtm_trib_cfg_t [`ODTM_NTRIB-1:0]         tcfg;
    logic [`ODTM_TW-1:0]                      idx;
    logic [6:0][7:0]                          cnt;
    logic [`ODTM_SW-1:0]                      sum;
    logic [`ODTM_SW-1:0]                      cap;
    logic [`ODTM_NTRIB-1:0][`ODTM_SW-1:0]     startp;
    logic [`ODTM_NTRIB-1:0][`ODTM_SW-1:0]     endp;
    logic [`ODTM_NTRIB-1:0]                   amp;
    logic [`ODTM_NTRIB-1:0]                   part;
    odtm_err_t                                err;
    logic [`ODTM_TW-1:0]                      err_trib;
    logic                                     busy;
    logic                                     ok;
    logic                                     bad;
    logic [`ODTM_SW-1:0]                      slot;
    logic [`ODTM_TW-1:0]                      owner;
    logic                                     hit;
    logic                                     go;
    logic [`ODTM_NTRIB-1:0]                   rdy;
    logic [7:0]                               pt_tag;
  } odtm_st_t;
endpackage
`default_nettype wire

// File: odtm_buf.sv
/*
  Two-entry buffer between the slot sequencer and the higher-order framer.
  Assumes one clock and a synchronous active-high reset; head word and valid are flops.
*/
`timescale 1ns/1ns
`default_nettype none
module odtm_buf
  import odtm_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // filling side
  input  wire logic                in_valid,
  input  wire odtm_pkg::odtm_word_t in_word,
  output logic                     in_ready,
  // draining side
  output logic                     out_valid,
  output var odtm_pkg::odtm_word_t out_word,
  input  wire logic                out_ready,
  // occupancy for the sequencer's look-ahead
  output logic [1:0]               level
);
  odtm_buf_st_t s_ff;
  odtm_buf_st_t nxt_s_ff;

  // head always sits in entry 0, so the output needs no read mux
  assign out_valid = s_ff.v[0];
  assign out_word  = s_ff.e[0];
  assign in_ready  = !s_ff.v[1];
  assign level     = {1'b0, s_ff.v[0]} + {1'b0, s_ff.v[1]};

  // pop shifts entry 1 forward, then a push lands in the first free entry
  always_comb
  begin
    nxt_s_ff = s_ff;
    if (s_ff.v[0] && out_ready)
    begin
      nxt_s_ff.e[0] = s_ff.e[1];
      nxt_s_ff.v    = {1'b0, s_ff.v[1]};
    end
    if (in_valid && !s_ff.v[1])
    begin
      if (!nxt_s_ff.v[0])
      begin
        nxt_s_ff.e[0] = in_word;
        nxt_s_ff.v[0] = 1'b1;
      end
      else
      begin
        nxt_s_ff.e[1] = in_word;
        nxt_s_ff.v[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      s_ff <= '0;
    else
      s_ff <= nxt_s_ff;
  end
endmodule
`default_nettype wire

// File: odtm_slot_map.sv
/*
  Finds which tributary owns a given tributary slot position.
  Assumes slot ranges are disjoint; the lowest index wins if not.
*/
`timescale 1ns/1ns
`default_nettype none
module odtm_slot_map
  import odtm_pkg::*;
(
  // slot to look up
  input  wire logic [`ODTM_SW-1:0]                  slot,
  // per-tributary ranges
  input  wire odtm_pkg::odtm_trib_cfg_t [`ODTM_NTRIB-1:0] tcfg,
  input  wire logic [`ODTM_NTRIB-1:0][`ODTM_SW-1:0] startp,
  input  wire logic [`ODTM_NTRIB-1:0][`ODTM_SW-1:0] endp,
  // result
  output logic [`ODTM_TW-1:0]                       owner,
  output logic                                      hit
);
  logic [`ODTM_NTRIB-1:0] match;

  // each enabled tributary owns the contiguous range [start, end)
  for (genvar i = 0; i < `ODTM_NTRIB; i++)
  begin : g_match
    assign match[i] = tcfg[i].en && (slot >= startp[i]) && (slot < endp[i]);
  end

  // priority encode, lowest index first
  always_comb
  begin
    owner = '0;
    hit   = 1'b0;
    for (int i = `ODTM_NTRIB - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        owner = `ODTM_TW'(i);
        hit   = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: odtm_mux.sv
/*
  Tributary time-division multiplexer: checks a tributary mix against the
  capacity of the chosen container, assigns tributary slots and justification
  type, and interleaves tributary words into the higher-order payload stream.
  Assumes tributary framers and the higher-order framer run on mclk, and that
  justification arithmetic and overhead insertion happen downstream.
*/
`timescale 1ns/1ns
`default_nettype none
`include "odtm_regs.svh"
module odtm_mux
  import odtm_pkg::*;
(
  // clock and reset
  input  wire logic                                       mclk,
  input  wire logic                                       reset,
  // configuration
  input  wire logic                                       cfg_apply,
  input  wire odtm_pkg::odtm_cfg_t                        cfg_in,
  input  wire odtm_pkg::odtm_trib_cfg_t [`ODTM_NTRIB-1:0] trib_cfg,
  // configuration status
  output logic                                            cfg_busy,
  output logic                                            cfg_ok,
  output logic                                            cfg_err,
  output var odtm_pkg::odtm_err_t                         err_code,
  output logic [`ODTM_TW-1:0]                             err_trib,
  output logic [7:0]                                      pt_tag,
  output logic [`ODTM_NTRIB-1:0]                          trib_amp,
  output logic [`ODTM_NTRIB-1:0]                          trib_part,
  // tributary framers
  input  wire logic [`ODTM_NTRIB-1:0]                     trib_valid,
  input  wire logic [`ODTM_NTRIB-1:0][`ODTM_DW-1:0]       trib_data,
  output logic [`ODTM_NTRIB-1:0]                          trib_ready,
  // higher-order framer
  output logic                                            ho_valid,
  output var odtm_pkg::odtm_word_t                        ho_word,
  input  wire logic                                       ho_ready
);
  odtm_st_t            s_ff;
  odtm_st_t            nxt_s_ff;
  odtm_lk_t            lk;
  odtm_word_t          push_word;
  logic                buf_in_ready;
  logic [1:0]          buf_level;
  logic                pop;
  logic [2:0]          lvl_n;
  logic [`ODTM_SW-1:0] slot_n;
  logic [`ODTM_SW-1:0] slot_inc;
  logic [`ODTM_TW-1:0] owner_n;
  logic                hit_n;

  // per-rate limit, slot width and justification of one tributary
  function automatic odtm_lk_t lookup(input odtm_cfg_t c, input odtm_trib_cfg_t t);
    logic [55:0]  lim;
    logic [55:0]  slt;
    logic [6:0]   amp;
    logic [7:0]   tenn;
    logic [5:0]   sel;
    odtm_lk_t     r;
    lim  = '0;
    slt  = '0;
    amp  = '0;
    r    = '0;
    sel  = {t.rate, 3'b000};
    tenn = 8'({c.n, 3'b000}) + 8'({c.n, 1'b0});
    case (c.cont)
      ODTM_C1:
      begin
        r.pt_ok = (c.pt == `ODTM_PT_AMP);
        lim   = `ODTM_LIM_O1;
        slt   = `ODTM_SLT_O1;
        amp   = `ODTM_AMP_O1;
        r.cap = `ODTM_CAP_O1;
      end
      ODTM_C2:
      begin
        if (c.pt == `ODTM_PT_AMP)
        begin
          r.pt_ok = 1'b1;
          lim   = `ODTM_LIM_O2A;
          slt   = `ODTM_SLT_O2A;
          amp   = `ODTM_AMP_O2A;
          r.cap = `ODTM_CAP_O2A;
        end
        else
        begin
          r.pt_ok = (c.pt == `ODTM_PT_MIX);
          lim   = `ODTM_LIM_O2M;
          slt   = `ODTM_SLT_O2M;
          amp   = `ODTM_AMP_O2M;
          r.cap = `ODTM_CAP_O2M;
        end
      end
      ODTM_C3:
      begin
        if (c.pt == `ODTM_PT_AMP)
        begin
          r.pt_ok = 1'b1;
          // ODU2 takes four slots of sixteen
          lim   = `ODTM_LIM_O3A;
          slt   = `ODTM_SLT_O3A;
          amp   = `ODTM_AMP_O3A;
          r.cap = `ODTM_CAP_O3A;
        end
        else
        begin
          r.pt_ok = (c.pt == `ODTM_PT_MIX);
          lim   = `ODTM_LIM_O3M;
          slt   = `ODTM_SLT_O3M;
          amp   = `ODTM_AMP_O3M;
          r.cap = `ODTM_CAP_O3M;
        end
      end
      ODTM_C4:
      begin
        r.pt_ok = (c.pt == `ODTM_PT_MIX);
        lim   = `ODTM_LIM_O4;
        slt   = `ODTM_SLT_O4;
        r.cap = `ODTM_CAP_O4;
      end
      ODTM_C25:
      begin
        r.pt_ok = (c.pt == `ODTM_PT_MIX);
        lim   = `ODTM_LIM_O25;
        slt   = `ODTM_SLT_O25;
        r.cap = `ODTM_CAP_O25;
      end
      ODTM_C50:
      begin
        r.pt_ok = (c.pt == `ODTM_PT_MIX);
        lim   = `ODTM_LIM_O50;
        slt   = `ODTM_SLT_O50;
        r.cap = `ODTM_CAP_O50;
      end
      ODTM_CN:
      begin
        // n of zero describes no container at all
        r.pt_ok = (c.pt == `ODTM_PT_CN) && (c.n != 4'h0);
        // 10n per rate, ODU3 int(10n/4), ODU4 n
        lim   = {tenn, 8'(c.n), 8'(tenn >> 2), tenn, tenn, tenn, tenn};
        slt   = `ODTM_SLT_CN;
        r.cap = `ODTM_SW'({c.n, 4'b0000}) + `ODTM_SW'({c.n, 2'b00});
      end
      default:
      begin
        r.pt_ok = 1'b0;
      end
    endcase
    r.limit = lim[sel +: 8];
    r.slots = (t.rate == RATE_FLEX) ? `ODTM_SW'(t.ts) : `ODTM_SW'(slt[sel +: 8]);
    r.amp   = amp[t.rate];
    // small rates under-fill a 5G slot
    r.part  = (c.cont == ODTM_CN) && ((t.rate == RATE_0) || (t.rate == RATE_1));
    return r;
  endfunction

  // the tributary under inspection during the check walk
  assign lk = lookup(s_ff.cfg, s_ff.tcfg[s_ff.idx]);

  // status outputs are all plain state bits
  assign cfg_busy   = s_ff.busy;
  assign cfg_ok     = s_ff.ok;
  assign cfg_err    = s_ff.bad;
  assign err_code   = s_ff.err;
  assign err_trib   = s_ff.err_trib;
  assign pt_tag     = s_ff.pt_tag;
  assign trib_amp   = s_ff.amp;
  assign trib_part  = s_ff.part;
  assign trib_ready = s_ff.rdy;

  // buffer occupancy one cycle ahead decides whether the next slot may go
  assign pop      = ho_valid && ho_ready;
  assign lvl_n    = {1'b0, buf_level} + {2'b00, s_ff.go} - {2'b00, pop};
  assign slot_inc = s_ff.slot + `ODTM_SW'(1);

  // the slot counter only moves on a served slot and wraps at container size
  always_comb
  begin
    if (s_ff.fsm != ST_RUN)
      slot_n = '0;
    else if (!s_ff.go)
      slot_n = s_ff.slot;
    else if (slot_inc >= s_ff.cap)
      slot_n = '0;
    else
      slot_n = slot_inc;
  end

  // owner of the slot that will be served next
  odtm_slot_map u_map
  (
    .slot   (slot_n),
    .tcfg   (s_ff.tcfg),
    .startp (s_ff.startp),
    .endp   (s_ff.endp),
    .owner  (owner_n),
    .hit    (hit_n)
  );

  // word for the slot served this cycle
  always_comb
  begin
    push_word      = '0;
    // no group framing: each word is one slot of the payload
    push_word.trib = s_ff.owner;
    push_word.used = s_ff.hit;
    push_word.slot = s_ff.slot;
    if (s_ff.hit)
    begin
      // a missing word becomes a justification opportunity downstream
      push_word.fill = !trib_valid[s_ff.owner];
      push_word.amp  = s_ff.amp[s_ff.owner];
      push_word.part = s_ff.part[s_ff.owner];
      push_word.data = trib_valid[s_ff.owner] ? trib_data[s_ff.owner] : '0;
    end
  end

  // configuration check and slot sequencer
  always_comb
  begin
    nxt_s_ff = s_ff;
    case (s_ff.fsm)
      ST_IDLE, ST_RUN, ST_FAULT:
      begin
        // a new mix is only taken while no check is in flight
        if (cfg_apply)
        begin
          nxt_s_ff.fsm      = ST_CHECK;
          nxt_s_ff.cfg      = cfg_in;
          nxt_s_ff.tcfg     = trib_cfg;
          nxt_s_ff.idx      = '0;
          nxt_s_ff.cnt      = '0;
          nxt_s_ff.sum      = '0;
          nxt_s_ff.startp   = '0;
          nxt_s_ff.endp     = '0;
          nxt_s_ff.amp      = '0;
          nxt_s_ff.part     = '0;
          nxt_s_ff.err      = ERR_NONE;
          nxt_s_ff.err_trib = '0;
          nxt_s_ff.busy     = 1'b1;
          nxt_s_ff.ok       = 1'b0;
          nxt_s_ff.bad      = 1'b0;
          nxt_s_ff.pt_tag   = '0;
        end
      end
      ST_CHECK:
      begin
        nxt_s_ff.cap = lk.cap;
        // payload type must match the container structure
        if (!lk.pt_ok)
        begin
          nxt_s_ff.fsm = ST_FAULT;
          nxt_s_ff.err = ERR_PT;
        end
        // rate not carried by this container
        else if (s_ff.tcfg[s_ff.idx].en && (lk.limit == 8'h00))
        begin
          nxt_s_ff.fsm = ST_FAULT;
          nxt_s_ff.err = ERR_RATE;
        end
        else if (s_ff.tcfg[s_ff.idx].en && (lk.slots == '0))
        begin
          nxt_s_ff.fsm = ST_FAULT;
          nxt_s_ff.err = ERR_TS;
        end
        else if (s_ff.tcfg[s_ff.idx].en && (s_ff.cnt[s_ff.tcfg[s_ff.idx].rate] >= lk.limit))
        begin
          nxt_s_ff.fsm = ST_FAULT;
          nxt_s_ff.err = ERR_COUNT;
        end
        else
        begin
          if (s_ff.tcfg[s_ff.idx].en)
          begin
            nxt_s_ff.cnt[s_ff.tcfg[s_ff.idx].rate] = s_ff.cnt[s_ff.tcfg[s_ff.idx].rate] + 8'h01;
            // slots are packed back to back in tributary order
            nxt_s_ff.startp[s_ff.idx] = s_ff.sum;
            nxt_s_ff.endp[s_ff.idx]   = s_ff.sum + lk.slots;
            nxt_s_ff.sum              = s_ff.sum + lk.slots;
            nxt_s_ff.amp[s_ff.idx]    = lk.amp;
            nxt_s_ff.part[s_ff.idx]   = lk.part;
          end
          if (s_ff.idx == `ODTM_TW'(`ODTM_NTRIB - 1))
            nxt_s_ff.fsm = ST_FINAL;
          else
            nxt_s_ff.idx = s_ff.idx + `ODTM_TW'(1);
        end
        if (nxt_s_ff.fsm == ST_FAULT)
          nxt_s_ff.err_trib = s_ff.idx;
      end
      ST_FINAL:
      begin
        // combined slot use must fit the container
        if (s_ff.sum > s_ff.cap)
        begin
          nxt_s_ff.fsm = ST_FAULT;
          nxt_s_ff.err = ERR_SLOTS;
        end
        else
        begin
          nxt_s_ff.fsm    = ST_RUN;
          nxt_s_ff.ok     = 1'b1;
          // tag the group with its payload type
          nxt_s_ff.pt_tag = s_ff.cfg.pt;
        end
      end
      default:
      begin
        nxt_s_ff.fsm = ST_IDLE;
      end
    endcase

    // a faulted mix leaves every tributary stalled until the next apply
    if (nxt_s_ff.fsm == ST_FAULT)
    begin
      nxt_s_ff.bad  = 1'b1;
      nxt_s_ff.busy = 1'b0;
    end
    if (nxt_s_ff.fsm == ST_RUN)
      nxt_s_ff.busy = 1'b0;

    // commit the next slot only if the buffer is sure to have room for it
    nxt_s_ff.slot  = slot_n;
    nxt_s_ff.owner = owner_n;
    nxt_s_ff.hit   = hit_n;
    nxt_s_ff.go    = (nxt_s_ff.fsm == ST_RUN) && (lvl_n < `ODTM_BUF_FULL);
    // ready is registered with go, so it is high in the cycle its slot is served, only towards the owner of that slot
    nxt_s_ff.rdy   = '0;
    if (nxt_s_ff.go && hit_n)
      nxt_s_ff.rdy[owner_n] = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      s_ff <= '0;
    else
      s_ff <= nxt_s_ff;
  end

  // two-entry buffer absorbs a stall of the higher-order framer
  odtm_buf u_buf
  (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (s_ff.go),
    .in_word   (push_word),
    .in_ready  (buf_in_ready),
    .out_valid (ho_valid),
    .out_word  (ho_word),
    .out_ready (ho_ready),
    .level     (buf_level)
  );

  // the look-ahead keeps the buffer from ever being full when go is set;
  // buf_in_ready only drives unused_ready, which nothing reads
  logic unused_ready;
  assign unused_ready = buf_in_ready;
endmodule
`default_nettype wire

// File: odtm_mux_assertions.sv
/* port checker of the tributary multiplexer.
   assumes odtm_pkg is compiled first; bound to odtm_mux below. */
`timescale 1ns/1ns
`default_nettype none
`include "odtm_regs.svh"
module odtm_mux_chk
  import odtm_pkg::*;
(
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    reset,
  // configuration
  input wire logic                    cfg_apply,
  input wire logic                    cfg_busy,
  input wire logic                    cfg_ok,
  input wire logic                    cfg_err,
  input wire odtm_pkg::odtm_err_t     err_code,
  input wire logic [7:0]              pt_tag,
  input wire logic [`ODTM_NTRIB-1:0]  trib_amp,
  input wire logic [`ODTM_NTRIB-1:0]  trib_part,
  // stream
  input wire logic [`ODTM_NTRIB-1:0]  trib_ready,
  input wire logic                    ho_valid,
  input wire odtm_pkg::odtm_word_t    ho_word,
  input wire logic                    ho_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // a check starts one edge after it is taken
  busy_on_apply_a: assert property (cfg_apply && !cfg_busy |=> cfg_busy)
    else $error("check did not start");
  // the check walks at most eight tributaries plus a final step
  busy_bound_a: assert property ($rose(cfg_busy) |-> ##[1:9] !cfg_busy)
    else $error("check ran too long");
  verdict_excl_a: assert property (!(cfg_ok && cfg_err))
    else $error("accept and reject together");
  // a rejected mix moves no words
  err_quiet_a: assert property (cfg_err |-> trib_ready == '0 && err_code != ERR_NONE)
    else $error("rejected mix still active");
  ok_code_a: assert property (cfg_ok |-> err_code == ERR_NONE && pt_tag inside {8'h20, 8'h21, 8'h22})
    else $error("running group has bad tag");
  pt_idle_a: assert property (!cfg_ok |-> pt_tag == 8'h00)
    else $error("tag shown while not running");
  slot_owner_a: assert property (|trib_ready |-> cfg_ok && $onehot(trib_ready))
    else $error("slot served by several tributaries");
  part_gmp_a: assert property (cfg_ok |-> (trib_amp & trib_part) == '0)
    else $error("partial slot marked as amp");
  part_cn_a: assert property (cfg_ok && pt_tag != 8'h22 |-> trib_part == '0)
    else $error("partial slot outside the cn group");
  // a stalled head word must not change under the framer
  ho_hold_a: assert property (ho_valid && !ho_ready && !cfg_apply |=> ho_valid && $stable(ho_word))
    else $error("head word changed while stalled");
  fill_zero_a: assert property (ho_valid && ho_word.fill |-> ho_word.data == '0 && ho_word.used)
    else $error("fill word carries data");
  cover property ($rose(cfg_ok));
  cover property ($rose(cfg_err));
  cover property (ho_valid && !ho_ready);
  cover property (ho_valid && ho_word.fill);
endmodule
bind odtm_mux odtm_mux_chk chk_u (.mclk, .reset, .cfg_apply, .cfg_busy, .cfg_ok, .cfg_err, .err_code,
  .pt_tag, .trib_amp, .trib_part, .trib_ready, .ho_valid, .ho_word, .ho_ready);
`default_nettype wire

// File: odtm_trib_model.sv
/* far side: tributary framers and the higher-order framer.
   assumes the bench drives stall and gap at rising edges. */
`timescale 1ns/1ns
`default_nettype none
`include "odtm_regs.svh"
module odtm_trib_model
  import odtm_pkg::*;
(
  // clock and reset
  input wire logic                                mclk,
  input wire logic                                reset,
  // scenario controls
  input wire logic                                stall,
  input wire logic [`ODTM_NTRIB-1:0]              gap,
  // tributary framers
  input wire logic [`ODTM_NTRIB-1:0]              trib_ready,
  output logic [`ODTM_NTRIB-1:0]                  trib_valid,
  output logic [`ODTM_NTRIB-1:0][`ODTM_DW-1:0]    trib_data,
  // higher-order framer
  output logic                                    ho_ready
);
  logic [`ODTM_NTRIB-1:0][23:0] cnt_ff;
  logic [2:0]                   cyc_ff;
  // a word counter moves only when its word is taken
  always_ff @(posedge mclk)
  begin
    cyc_ff <= reset ? 3'h0 : cyc_ff + 3'h1;
    for (int i = 0; i < `ODTM_NTRIB; i++)
      if (reset) cnt_ff[i] <= 24'h0;
      else if (trib_valid[i] && trib_ready[i]) cnt_ff[i] <= cnt_ff[i] + 24'h1;
  end
  // absent words show inverted data so a stale word never looks valid
  always_comb
  begin
    trib_valid = ~gap;
    for (int i = 0; i < `ODTM_NTRIB; i++)
      trib_data[i] = gap[i] ? ~{8'(i), cnt_ff[i]} : {8'(i), cnt_ff[i]};
  end
  // a stalled framer accepts one cycle in eight
  assign ho_ready = !stall || (cyc_ff == 3'h0);
endmodule
`default_nettype wire

// File: test_odtm_mux.sv
/* self-checking bench of the tributary multiplexer.
   assumes the package, checker and far-side model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_odtm_mux;
  import odtm_pkg::*;
  logic mclk = 0, reset = 1, cfg_apply = 0, stall = 0, cfg_busy, cfg_ok, cfg_err, ho_valid, ho_ready;
  logic [7:0] gap = 0, pt_tag, trib_amp, trib_part, trib_ready, trib_valid;
  logic [2:0] err_trib;
  logic [7:0][31:0] trib_data;
  odtm_cfg_t cfg_in = '0;
  odtm_trib_cfg_t [7:0] trib_cfg = '0;
  odtm_err_t err_code;
  odtm_word_t ho_word;
  logic [23:0] wexp [3] = '{default: 24'h0};
  int errors = 0, check_count = 0, s = 0, fills = 0;

  always #50 mclk = ~mclk;
  odtm_mux dut_u (.mclk, .reset, .cfg_apply, .cfg_in, .trib_cfg, .cfg_busy, .cfg_ok, .cfg_err, .err_code,
    .err_trib, .pt_tag, .trib_amp, .trib_part, .trib_valid, .trib_data, .trib_ready, .ho_valid, .ho_word,
    .ho_ready);
  odtm_trib_model far_u (.mclk, .reset, .stall, .gap, .trib_ready, .trib_valid, .trib_data, .ho_ready);

  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // tributaries 0..cnt-1 take rate r, the last of them rate lst; pa is {part, amp}; ts is 0 only for ERR_TS
  task automatic apply(input odtm_cont_t c, input logic [7:0] pt, input logic [3:0] n, input odtm_rate_t r,
    lst, input int cnt, input odtm_err_t ec, input logic [2:0] et, input logic [15:0] pa);
    @(posedge mclk);
    cfg_in <= '{c, pt, n};
    for (int i = 0; i < 8; i++)
      trib_cfg[i] <= '{i < cnt, (i == cnt - 1) ? lst : r, (ec == ERR_TS) ? 8'h00 : 8'h01};
    cfg_apply <= 1'b1;
    @(posedge mclk);
    cfg_apply <= 1'b0;
    repeat (12)
    begin
      @(negedge mclk);
      if (!cfg_busy) break;
    end
    chk(cfg_err, ec != ERR_NONE);
    chk(err_code, ec);
    if (ec != ERR_NONE) chk(err_trib, et);
    else chk({pt_tag, trib_part, trib_amp}, {pt, pa});
  endtask

  // collect nw words; slots 0..2 owned, slot 3 unowned
  task automatic take(input int nw);
    for (int k = 0; k < 400 && nw > 0; k++)
    begin
      @(negedge mclk);
      if (ho_valid && ho_ready)
      begin
        nw--;
        fills += ho_word.fill;
        chk(ho_word.slot, s);
        chk(ho_word.used, s < 3);
        if (s < 3) chk({ho_word.trib, ho_word.amp, ho_word.part}, {s[2:0], 1'b1, 1'b0});
        if (s < 3 && !ho_word.fill)
        begin
          chk(ho_word.data, {8'(s), wexp[s]});
          wexp[s]++;
        end
        s = (s + 1) % 4;
      end
    end
    chk(nw, 0);
  endtask

  task automatic t_stream();
    apply(ODTM_C2, 8'h20, 0, RATE_1, RATE_1, 3, ERR_NONE, 0, 16'h0007);
    @(posedge mclk);
    stall <= 1'b1;
    take(20);
    @(posedge mclk);
    stall <= 1'b0;
    gap <= 8'h02;
    take(40);
    chk(fills >= 5, 1);
    $display("stream test done");
  endtask

  task automatic t_amp();
    apply(ODTM_C1, 8'h20, 0, RATE_0, RATE_0, 2, ERR_NONE, 0, 16'h0003);
    apply(ODTM_C1, 8'h20, 0, RATE_0, RATE_0, 3, ERR_COUNT, 2, 0);
    apply(ODTM_C1, 8'h21, 0, RATE_0, RATE_0, 1, ERR_PT, 0, 0);
    apply(ODTM_C2, 8'h20, 0, RATE_1, RATE_1, 4, ERR_NONE, 0, 16'h000F);
    apply(ODTM_C3, 8'h20, 0, RATE_2, RATE_1, 4, ERR_NONE, 0, 16'h000F);
    apply(ODTM_C3, 8'h20, 0, RATE_2, RATE_1, 5, ERR_SLOTS, 0, 0);
    $display("amp group test done");
  endtask

  task automatic t_mix();
    apply(ODTM_C2, 8'h21, 0, RATE_0, RATE_1, 6, ERR_NONE, 0, 16'h0020);
    apply(ODTM_C2, 8'h21, 0, RATE_FLEX, RATE_FLEX, 8, ERR_NONE, 0, 0);
    apply(ODTM_C2, 8'h21, 0, RATE_FLEX, RATE_FLEX, 1, ERR_TS, 0, 0);
    apply(ODTM_C3, 8'h21, 0, RATE_2E, RATE_0, 4, ERR_NONE, 0, 0);
    apply(ODTM_C3, 8'h21, 0, RATE_2E, RATE_2E, 4, ERR_COUNT, 3, 0);
    apply(ODTM_C4, 8'h21, 0, RATE_3, RATE_3, 3, ERR_COUNT, 2, 0);
    apply(ODTM_C4, 8'h20, 0, RATE_0, RATE_0, 1, ERR_PT, 0, 0);
    apply(ODTM_C25, 8'h21, 0, RATE_3, RATE_3, 1, ERR_RATE, 0, 0);
    apply(ODTM_C50, 8'h21, 0, RATE_3, RATE_3, 2, ERR_COUNT, 1, 0);
    $display("mixed group test done");
  endtask

  task automatic t_cn();
    apply(ODTM_CN, 8'h22, 1, RATE_4, RATE_4, 2, ERR_COUNT, 1, 0);
    apply(ODTM_CN, 8'h22, 1, RATE_0, RATE_3, 8, ERR_NONE, 0, 16'h7F00);
    apply(ODTM_CN, 8'h22, 0, RATE_0, RATE_0, 1, ERR_PT, 0, 0);
    $display("cn group test done");
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_stream();
    t_amp();
    t_mix();
    t_cn();
    stop_test();
  end

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge mclk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
